// File: include/tx_pkg.sv
// Constants, register map and carrier types for the asynchronous character transmitter.
// Assumes a 32-bit Avalon-MM slave port and a single 125 MHz system clock.
package tx_pkg;

  // Clock
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned BAUD_DEFAULT    = 9600;
  localparam int unsigned DIV_RESET       = CLK_HZ / (2 * BAUD_DEFAULT);

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_DIV    = 4'h4;
  localparam logic [3:0] OFS_DATA   = 4'h8;
  localparam logic [3:0] OFS_CMD    = 4'hC;
  localparam int unsigned ADDR_W    = 4;

  // CTRL fields
  localparam int unsigned CTRL_LEN_LSB  = 0;
  localparam int unsigned CTRL_STOP_LSB = 2;
  localparam int unsigned CTRL_FDX_BIT  = 4;
  localparam int unsigned CTRL_RSTR_BIT = 5;
  localparam int unsigned CTRL_BRKEN_BIT = 6;
  localparam int unsigned CTRL_SEL_BIT  = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h03;

  // DATA word fields
  localparam int unsigned DATA_BRK_SET_BIT = 10;
  localparam int unsigned DATA_BRK_CLR_BIT = 11;

  // CMD fields (write-only pulses)
  localparam int unsigned CMD_ENA_BIT = 0;
  localparam int unsigned CMD_DIS_BIT = 1;
  localparam int unsigned CMD_MCLR_BIT = 2;

  // Serializer
  localparam int unsigned HOLD_FORCE_BIT = 1;
  localparam logic [3:0]  STOP_UPPER     = 4'hA;
  localparam logic [3:0]  CNT_MAX        = 4'hF;

  typedef enum logic [1:0] {
    LEN_5 = 2'h0,
    LEN_6 = 2'h1,
    LEN_7 = 2'h2,
    LEN_8 = 2'h3
  } char_len_t;

  typedef enum logic [1:0] {
    STOP_1   = 2'h0,
    STOP_1H  = 2'h1,
    STOP_2   = 2'h2
  } stop_len_t;

  typedef struct packed {
    logic       select_input;
    logic       break_en;
    logic       restraint_en;
    logic       full_duplex;
    stop_len_t  stop_len;
    char_len_t  char_len;
  } ctrl_t;

  typedef struct packed {
    logic dsr;
    logic cts;
    logic restraint;
  } modem_in_t;

  typedef struct packed {
    logic tx_data;
    logic rts;
    logic activity;
  } modem_out_t;

endpackage

// File: rtl/char_transmitter.sv
// Transmit side of an asynchronous communications adapter with an Avalon-MM register port.
// Assumes one clock, an asynchronous active-low reset and modem inputs from another clock source.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps

// What this block does
// R1 - Four-stage bit counter, maximum 15, cleared at every character start.
// R2 - First odd pulse sets even-gate flag; only then even pulses reach counter and shifter.
// R3 - Each gated even pulse advances the bit counter by one, except at 15 or on a halting pulse.
// R4 - Five-bit characters: first odd pulse presets counter to three.
// R5 - Six-bit presets counter to two, seven-bit to one; counting otherwise unchanged.
// R6 - Character length is static configuration: 5, 6, 7 or 8 bits.
// R7 - Eight-bit holding register loads all data bits in parallel on host write.
// R8 - Five- or six-bit length forces holding register stage two to one.
// R9 - First gated even pulse copies set holding bits into the serializer.
// R10 - Later gated even pulses shift serializer one place toward the output.
// R11 - Serializer output drives transmit line only while break flag is clear.
// R12 - Activity indicator pulses each time a bit leaves the output stage.
// R13 - Half duplex: send-request follows character-request enable flag.
// R14 - Master clear clears the character-request enable flag.
// R15 - Full duplex: send-request held set, reaches modem only with data set ready.
// R16 - Stop interval of one, one and a half or two bit times, static.
// R17 - Clock-run clears when stop decode meets count ten (eleven for two stop bits), halting clock and counter.
// R18 - Enable command with read select sets the character-request enable flag.
// R19 - Character request needs select, enable, no load pending, transfer done, permission.
// R20 - Restraint option: active restraint suppresses the request despite clear-to-send.
// R21 - Without restraint option, clear-to-send grants the line permission.
// R22 - Host write sets load-pending, which starts the clock; first odd pulse clears it.
// R23 - Write bit 10 low sets break; with break enabled bit 11 low clears it.
// R24 - Master clear clears clock-run, phase, load-pending, send-request and break flags.
// R25 - Bit timing from programmable system clock divider; ticks alternate odd and even.
// R26 - Everything changes on the system clock; external strobes are synchronized.
module char_transmitter #(
  parameter int unsigned DIV_W = 16
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  // Avalon-MM slave
  input  wire logic [tx_pkg::ADDR_W-1:0] address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  output logic      [31:0]              readdata,
  output logic                          waitrequest,
  // Modem side
  input  wire tx_pkg::modem_in_t        modem_in,
  output tx_pkg::modem_out_t            modem_out,
  // Character request toward the multiplexer
  output logic                          char_request
);

  initial begin
    if (DIV_W < 2 || DIV_W > 32) begin
      $error("DIV_W must be between 2 and 32");
    end
  end

  // Bus decode helpers
  function automatic logic hit(input logic [tx_pkg::ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ofs[tx_pkg::ADDR_W-1:0]);
  endfunction

  // Positions above the character length go out as mark, so the stop interval
  // always follows the last data bit instead of a leftover holding bit
  function automatic logic [7:0] fill_mask(input tx_pkg::char_len_t len);
    case (len)
      tx_pkg::LEN_5: fill_mask = 8'hE0;
      tx_pkg::LEN_6: fill_mask = 8'hC0;
      tx_pkg::LEN_7: fill_mask = 8'h80;
      default:       fill_mask = 8'h00;
    endcase
  endfunction

  logic                   acc_go;
  logic                   wr_go;
  tx_pkg::ctrl_t          ctrl_reg;
  logic [DIV_W-1:0]       div_reg;
  logic [DIV_W-1:0]       div_cnt_reg;
  logic [2:0]             sync1_reg;
  logic [2:0]             sync2_reg;
  logic                   dsr_s;
  logic                   cts_s;
  logic                   restraint_s;
  logic                   data_wr;
  logic                   cmd_wr;
  logic                   mclr;
  logic                   clock_run_flag;
  logic                   phase_reg;
  logic                   tick;
  logic                   odd_pulse;
  logic                   even_pulse;
  logic                   even_gate_enable_flag;
  logic                   first_odd;
  logic                   gated_even;
  logic                   loaded_reg;
  logic                   halt;
  logic [3:0]             bit_cnt_reg;
  logic [3:0]             bit_cnt_next;
  logic [7:0]             hold_reg;
  logic [8:0]             shift_reg;
  logic                   xfer_done_reg;
  logic                   load_pending_flag;
  logic                   char_request_enable_flag;
  logic                   send_request_flag;
  logic                   line_break_flag;
  logic                   permit;
  logic                   char_request_next;
  logic [31:0]            status;

  // A request is answered one cycle after it appears; the write acts at the answering edge
  assign acc_go = (read | write) & waitrequest;
  assign wr_go  = write & ~waitrequest;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~acc_go;
    end
  end

  assign status = {16'h0000, 8'h00, ctrl_reg.select_input, xfer_done_reg, line_break_flag,
                   send_request_flag, char_request_enable_flag, load_pending_flag,
                   clock_run_flag, even_gate_enable_flag};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (acc_go && read) begin
      if (hit(address, tx_pkg::OFS_CTRL)) begin
        readdata <= {24'h00_0000, ctrl_reg};
      end else if (hit(address, tx_pkg::OFS_DIV)) begin
        readdata <= 32'(div_reg);
      end else if (hit(address, tx_pkg::OFS_DATA)) begin
        readdata <= {24'h00_0000, hold_reg};
      end else if (hit(address, tx_pkg::OFS_CMD)) begin
        readdata <= status;
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  // Length and stop settings are meant to be written once before traffic starts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= tx_pkg::ctrl_t'(tx_pkg::CTRL_RESET);
      div_reg  <= DIV_W'(tx_pkg::DIV_RESET);
    end else if (wr_go) begin
      if (hit(address, tx_pkg::OFS_CTRL)) begin
        ctrl_reg <= tx_pkg::ctrl_t'(writedata[7:0]); // [R6] [R16]
      end
      if (hit(address, tx_pkg::OFS_DIV)) begin
        div_reg <= writedata[DIV_W-1:0];
      end
    end
  end

  assign data_wr = wr_go & hit(address, tx_pkg::OFS_DATA);
  assign cmd_wr  = wr_go & hit(address, tx_pkg::OFS_CMD);
  assign mclr    = cmd_wr & writedata[tx_pkg::CMD_MCLR_BIT];

  // Modem lines are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= modem_in; // [R26]
      sync2_reg <= sync1_reg;
    end
  end
  assign dsr_s       = sync2_reg[2];
  assign cts_s       = sync2_reg[1];
  assign restraint_s = sync2_reg[0];

  // Bit-rate divider: each tick is half a bit time
  assign tick       = clock_run_flag && (div_cnt_reg == '0);
  assign odd_pulse  = tick & ~phase_reg;
  assign even_pulse = tick & phase_reg;
  assign first_odd  = odd_pulse & ~even_gate_enable_flag;
  assign gated_even = even_pulse & even_gate_enable_flag; // [R2]

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= '0;
    end else if (!clock_run_flag) begin
      div_cnt_reg <= '0;
    end else if (div_cnt_reg == '0) begin
      div_cnt_reg <= div_reg; // [R25]
    end else begin
      div_cnt_reg <= div_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 1'b0;
    end else if (mclr || !clock_run_flag) begin
      phase_reg <= 1'b0; // [R24]
    end else if (tick) begin
      phase_reg <= ~phase_reg; // [R25]
    end
  end

  // Stop decode: upper stages at ten, low stages and phase pick the stop length
  always_comb begin
    halt = 1'b0;
    if (bit_cnt_reg[3:2] == tx_pkg::STOP_UPPER[3:2]) begin
      case (ctrl_reg.stop_len)
        tx_pkg::STOP_1:  halt = odd_pulse  && bit_cnt_reg[1:0] == tx_pkg::STOP_UPPER[1:0];
        tx_pkg::STOP_1H: halt = gated_even && bit_cnt_reg[1:0] == tx_pkg::STOP_UPPER[1:0];
        tx_pkg::STOP_2:  halt = odd_pulse  && bit_cnt_reg[1:0] == 2'h3;
        default:         halt = odd_pulse  && bit_cnt_reg[1:0] == tx_pkg::STOP_UPPER[1:0];
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clock_run_flag <= 1'b0;
    end else if (mclr || halt) begin
      clock_run_flag <= 1'b0; // [R17] [R24]
    end else if (load_pending_flag) begin
      clock_run_flag <= 1'b1; // [R22]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      even_gate_enable_flag <= 1'b0;
    end else if (!clock_run_flag || mclr) begin
      even_gate_enable_flag <= 1'b0;
    end else if (first_odd) begin
      even_gate_enable_flag <= 1'b1; // [R2]
    end
  end

  // Counter preset by character length at the first odd pulse
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    if (first_odd) begin
      case (ctrl_reg.char_len)
        tx_pkg::LEN_5: bit_cnt_next = 4'h3; // [R4]
        tx_pkg::LEN_6: bit_cnt_next = 4'h2; // [R5]
        tx_pkg::LEN_7: bit_cnt_next = 4'h1; // [R5]
        tx_pkg::LEN_8: bit_cnt_next = 4'h0;
        default:       bit_cnt_next = 4'h0;
      endcase
    end else if (gated_even && !halt && bit_cnt_reg != tx_pkg::CNT_MAX) begin
      bit_cnt_next = bit_cnt_reg + 4'h1; // [R3]
    end
  end

  // Holds at 15 at most; only a stopped clock brings it back to zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= 4'h0;
    end else if (!clock_run_flag) begin
      bit_cnt_reg <= 4'h0; // [R1]
    end else begin
      bit_cnt_reg <= bit_cnt_next; // [R1]
    end
  end

  // Holding register; writes while a character is serializing are allowed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= 8'h00;
    end else if (data_wr) begin
      hold_reg <= writedata[7:0]; // [R7]
      if (ctrl_reg.char_len == tx_pkg::LEN_5 || ctrl_reg.char_len == tx_pkg::LEN_6) begin
        hold_reg[tx_pkg::HOLD_FORCE_BIT] <= 1'b1; // [R8]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loaded_reg <= 1'b0;
    end else if (!clock_run_flag) begin
      loaded_reg <= 1'b0;
    end else if (gated_even) begin
      loaded_reg <= 1'b1;
    end
  end

  // Serializer: bit 0 is the output stage; idle and fill are mark
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= 9'h1FF;
    end else if (gated_even && !loaded_reg) begin
      shift_reg <= {hold_reg | fill_mask(ctrl_reg.char_len), 1'b0}; // [R9] [R16]
    end else if (gated_even) begin
      shift_reg <= {1'b1, shift_reg[8:1]}; // [R10]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      xfer_done_reg <= 1'b1;
    end else if (gated_even && !loaded_reg) begin
      xfer_done_reg <= 1'b1;
    end else if (data_wr) begin
      xfer_done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      load_pending_flag <= 1'b0;
    end else if (data_wr) begin
      load_pending_flag <= 1'b1; // [R22]
    end else if (mclr || first_odd) begin
      load_pending_flag <= 1'b0; // [R22] [R24]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      line_break_flag <= 1'b0;
    end else if (mclr) begin
      line_break_flag <= 1'b0; // [R24]
    end else if (data_wr && !writedata[tx_pkg::DATA_BRK_SET_BIT]) begin
      line_break_flag <= 1'b1; // [R23]
    end else if (data_wr && (!ctrl_reg.break_en || !writedata[tx_pkg::DATA_BRK_CLR_BIT])) begin
      line_break_flag <= 1'b0; // [R23]
    end
  end

  // Enable needs the read select; a master clear takes priority over both commands
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      char_request_enable_flag <= 1'b0;
    end else if (mclr) begin
      char_request_enable_flag <= 1'b0; // [R14]
    end else if (cmd_wr && ctrl_reg.select_input && writedata[tx_pkg::CMD_ENA_BIT]) begin
      char_request_enable_flag <= 1'b1; // [R18]
    end else if (cmd_wr && ctrl_reg.select_input && writedata[tx_pkg::CMD_DIS_BIT]) begin
      char_request_enable_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      send_request_flag <= 1'b0;
    end else if (mclr) begin
      send_request_flag <= 1'b0; // [R24]
    end else if (ctrl_reg.full_duplex) begin
      send_request_flag <= 1'b1; // [R15]
    end else begin
      send_request_flag <= char_request_enable_flag; // [R13]
    end
  end

  assign permit = ctrl_reg.restraint_en ? (cts_s & ~restraint_s) : cts_s; // [R20] [R21]
  assign char_request_next = ctrl_reg.select_input & char_request_enable_flag & ~load_pending_flag
                           & xfer_done_reg & permit; // [R19]

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      char_request <= 1'b0;
      modem_out    <= 3'b100;
    end else begin
      char_request       <= char_request_next;
      modem_out.tx_data  <= shift_reg[0] & ~line_break_flag; // [R11]
      modem_out.rts      <= send_request_flag & (~ctrl_reg.full_duplex | dsr_s); // [R15]
      modem_out.activity <= gated_even & loaded_reg; // [R12]
    end
  end

endmodule // char_transmitter

// File: test/char_transmitter_assertions.sv
// Concurrent checks on the transmitter's top-level ports.
// Assumes binding into char_transmitter; sees its ports only.
`timescale 1ns/100ps
module char_transmitter_assertions #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic                      clk_sys,
  input wire logic                      rst_b,
  input wire logic [tx_pkg::ADDR_W-1:0] address,
  input wire logic                      read,
  input wire logic                      write,
  input wire logic [31:0]               writedata,
  input wire logic [31:0]               readdata,
  input wire logic                      waitrequest,
  input wire tx_pkg::modem_in_t         modem_in,
  input wire tx_pkg::modem_out_t        modem_out,
  input wire logic                      char_request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_wait_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_rd_hold; !(read && waitrequest) |=> $stable(readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
  property p_reset_idle; $rose(rst_b) |-> waitrequest && modem_out.tx_data && !char_request; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_break;
    write && address == tx_pkg::OFS_DATA && !writedata[10] && !waitrequest |-> ##[1:2] !modem_out.tx_data;
  endproperty
  a_break: assert property (p_break) else $error("break did not space line");
  property p_act_pulse; modem_out.activity |=> !modem_out.activity; endproperty
  a_act_pulse: assert property (p_act_pulse) else $error("activity not a pulse");
  property p_no_cts; (!modem_in.cts)[*6] |-> !char_request; endproperty
  a_no_cts: assert property (p_no_cts) else $error("request without clear to send");
  property p_mclr;
    write && address == tx_pkg::OFS_CMD && writedata[2] && !waitrequest |-> ##[1:2] !char_request;
  endproperty
  a_mclr: assert property (p_mclr) else $error("request after master clear");
  property p_load;
    write && address == tx_pkg::OFS_DATA && !waitrequest |-> ##2 !char_request;
  endproperty
  a_load: assert property (p_load) else $error("request while load pending");
  c_req: cover property ($rose(char_request));
  c_act: cover property (modem_out.activity);
  c_brk: cover property (write && !writedata[10] && address == tx_pkg::OFS_DATA);
endmodule // char_transmitter_assertions

bind char_transmitter char_transmitter_assertions #(.DIV_W(DIV_W)) char_transmitter_assertions_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .modem_in(modem_in), .modem_out(modem_out), .char_request(char_request));

// File: test/modem_model.sv
// Data set model: drives handshake levels, counts bits leaving the line.
// Assumes the bench sets the wanted levels {dsr,cts,restraint}.
`timescale 1ns/100ps
module modem_model (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // Levels wanted by the bench
  input  wire logic [2:0]         want,
  // Line side
  input  wire tx_pkg::modem_out_t modem_out,
  output tx_pkg::modem_in_t       modem_in,
  output int                      acts
);
  // Levels change on the clock, not asynchronously as a real set would change them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      modem_in <= '0;
      acts     <= 0;
    end else begin
      modem_in <= tx_pkg::modem_in_t'(want);
      if (modem_out.activity) begin
        acts <= acts + 1;
      end
    end
  end
endmodule // modem_model

// File: test/tb_top.sv
// Self-checking bench for the character transmitter.
// Assumes DIV=2 so one bit lasts 6 clocks.
`timescale 1ns/100ps
module tb_top;
  logic               clk_sys, rst_b, read, write, waitrequest, char_request;
  logic [3:0]         address;
  logic [31:0]        writedata, readdata, rd, seed;
  logic [2:0]         want;
  tx_pkg::modem_in_t  modem_in;
  tx_pkg::modem_out_t modem_out;
  int                 miscompares = 0;
  int                 checks = 0;
  int                 acts;

  char_transmitter #(.DIV_W(16)) char_transmitter_i (.clk_sys(clk_sys), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .modem_in(modem_in), .modem_out(modem_out), .char_request(char_request));
  modem_model modem_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .want(want), .modem_out(modem_out),
    .modem_in(modem_in), .acts(acts));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, tx_pkg::OFS_CMD, 32'h0, rd);
      n++;
    end while (rd[1] !== 1'b0 && n < 60);
    chk("clock_run", rd[1], 1'b0);
    if (rd[1] !== 1'b0) print_verdict();
  endtask

  task automatic wait_cr(input logic v);
    int n;
    n = 0;
    while (char_request !== v && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk("char_request", char_request, v);
    if (char_request !== v) print_verdict();
  endtask

  // Expected frame is built as a queue: start, data LSB first, stop
  task automatic send_char(input int len, input logic [7:0] c);
    logic q[$];
    logic [7:0] hold;
    int n, a0;
    hold = (len < 2) ? (c | 8'h02) : c;
    q.push_back(1'b0);
    for (int i = 0; i < len + 5; i++) q.push_back(hold[i]);
    q.push_back(1'b1);
    a0 = acts;
    bus(1'b1, tx_pkg::OFS_DATA, {20'h0, 4'hC, c}, rd);
    n = 0;
    while (modem_out.tx_data !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      print_verdict();
    end
    repeat (3) @(posedge clk_sys);
    while (q.size() > 0) begin
      chk("tx_data", modem_out.tx_data, q.pop_front());
      repeat (6) @(posedge clk_sys);
    end
    wait_idle();
    chk("activity", (acts - a0) >= len + 5, 1'b1);
    bus(1'b0, tx_pkg::OFS_DATA, 32'h0, rd);
    chk("holding", rd[7:0], hold);
  endtask

  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    want = 3'b110;
    seed = 32'hECDE3D54;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(1'b0, tx_pkg::OFS_CTRL, 32'h0, rd);
    chk("ctrl", rd, 32'h03);
    bus(1'b0, tx_pkg::OFS_CMD, 32'h0, rd);
    chk("status", rd, 32'h40);
    chk("idle line", modem_out.tx_data, 1'b1);
    bus(1'b1, tx_pkg::OFS_DIV, 32'h2, rd);
    for (int l = 0; l < 8; l++) begin
      seed = lfsr(seed);
      bus(1'b1, tx_pkg::OFS_CTRL, 32'((l % 4) | ((l % 3) << 2)), rd);
      send_char(l % 4, seed[7:0]);
    end
    for (int be = 0; be < 2; be++) begin
      bus(1'b1, tx_pkg::OFS_CTRL, 32'(3 | (be << 6)), rd);
      bus(1'b1, tx_pkg::OFS_DATA, 32'h855, rd);
      repeat (5) @(posedge clk_sys);
      chk("break line", modem_out.tx_data, 1'b0);
      wait_idle();
      if (be == 1) begin
        bus(1'b1, tx_pkg::OFS_DATA, 32'hC55, rd);
        wait_idle();
        chk("break kept", rd[5], 1'b1);
      end
      bus(1'b1, tx_pkg::OFS_DATA, (be == 1) ? 32'h455 : 32'hC55, rd);
      wait_idle();
      chk("break cleared", rd[5], 1'b0);
      chk("mark", modem_out.tx_data, 1'b1);
    end
    bus(1'b1, tx_pkg::OFS_CTRL, 32'h83, rd);
    bus(1'b1, tx_pkg::OFS_CMD, 32'h1, rd);
    wait_cr(1'b1);
    repeat (2) @(posedge clk_sys);
    chk("rts", modem_out.rts, 1'b1);
    bus(1'b1, tx_pkg::OFS_CTRL, 32'hA3, rd);
    want <= 3'b111;
    wait_cr(1'b0);
    bus(1'b1, tx_pkg::OFS_CTRL, 32'h83, rd);
    wait_cr(1'b1);
    want <= 3'b100;
    wait_cr(1'b0);
    want <= 3'b110;
    wait_cr(1'b1);
    bus(1'b1, tx_pkg::OFS_CMD, 32'h2, rd);
    wait_cr(1'b0);
    repeat (3) @(posedge clk_sys);
    chk("rts off", modem_out.rts, 1'b0);
    bus(1'b1, tx_pkg::OFS_CMD, 32'h1, rd);
    wait_cr(1'b1);
    bus(1'b1, tx_pkg::OFS_CMD, 32'h4, rd);
    wait_cr(1'b0);
    bus(1'b0, tx_pkg::OFS_CMD, 32'h0, rd);
    chk("status after clear", rd[5:0], 6'h00);
    bus(1'b1, tx_pkg::OFS_CTRL, 32'h93, rd);
    want <= 3'b010;
    repeat (8) @(posedge clk_sys);
    chk("rts no dsr", modem_out.rts, 1'b0);
    want <= 3'b110;
    repeat (8) @(posedge clk_sys);
    chk("rts dsr", modem_out.rts, 1'b1);
    print_verdict();
  end
endmodule // tb_top
